// file: hw/ibf_pkg.sv
/*
  Shared constants and types of the two-wire bus framing block.
  Assumes a 100 MHz system clock; all hold counts are in its cycles.
*/
package ibf_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int HOLD_EXT_NS = 300;
  // Least time, so round up to whole cycles
  localparam int HOLD_EXT_CYC =
    (HOLD_EXT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_DEF_CYC = 1;

  // ----------------------------------------------------------------
  // Framing and addressing
  // ----------------------------------------------------------------
  localparam logic [3:0] BITS_DATA = 4'h8;
  localparam logic [3:0] BITS_UNIT = 4'h9;
  localparam logic [3:0] CNT_RST = 4'h0;
  localparam logic [4:0] HI_ADDR_TAG = 5'h1E;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [5:0] HOLD_RST = 6'h00;
  localparam logic [5:0] FALL_MAX = 6'h3F;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ADDR_LO = 3'b010,
    ST_RX = 3'b011,
    ST_TX = 3'b100,
    ST_SKIP = 3'b101
  } ibf_state_e;

  typedef struct packed {
    logic start;
    logic restart;
    logic stop;
    logic collision;
    logic rx_valid;
    logic tx_taken;
  } ibf_evt_s;

  localparam ibf_evt_s EVT_RST = '0;

  typedef struct packed {
    logic [9:0] own_address_value;
    logic addr_10bit;
    logic data_hold_extend;
  } ibf_cfg_s;

endpackage

// file: hw/ibf_framing.sv
/*
  Two-wire bus framing and slave condition logic: line sync, Start,
  Stop and Restart detection, 9-bit byte units, address match, ack,
  data shifting, extended data hold, clock stretch and collision.
  Assumes open-drain pins resolved outside: *_oe_out high pulls low.
*/
// What this block does
// - Each unit is eight data bits plus one acknowledge bit.
// - After eighth falling edge the driver releases data, samples ack.
// - Data changes only while clock low; sampled on clock rise.
// - Data change while clock high is a condition, not a bit.
// - Extended hold keeps driven data 300 ns past each clock fall.
// - Bus idle when no master and both lines high.
// - Start is data falling while clock high; bus becomes active.
// - Stop is data rising while clock high.
// - Stop valid only after a clock low following Start.
// - Restart resets slave logic like Start, ready for address.
// - 10-bit read needs full match, then Restart plus high byte.
// - Flag collision when data sampled low while outputting high.
// - Address matches only when equal to own address value.
// - Matching write address: slave clocks in data bytes.
// - Matching read address: slave sends bytes until nack, Restart or Stop.
// - Anyone may hold clock low; others wait for release.
// - Only one master wins; loser stops driving, winner intact.
// - Bytes go most significant bit first.
// - Ack is data low in the ninth bit period.
// - Lines are open-drain: pull low for zero, release for one.
module ibf_framing
  import ibf_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire ibf_cfg_s cfg_in,
  input wire logic [7:0] tx_data_in,
  input wire logic tx_valid_in,
  output logic scl_out,
  output logic scl_oe_out,
  output logic sda_out,
  output logic sda_oe_out,
  output logic [7:0] rx_data_out,
  output ibf_evt_s evt_out,
  output logic bus_active_out,
  output logic bus_idle_out,
  output logic read_mode_out
);

  // ----------------------------------------------------------------
  // Line synchronisers
  // ----------------------------------------------------------------
  logic [2:0] scl_sq;
  logic [2:0] sda_sq;

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      scl_sq <= 3'h7;
      sda_sq <= 3'h7;
    end
    else
    begin
      scl_sq <= {scl_sq[1:0], scl_in};
      sda_sq <= {sda_sq[1:0], sda_in};
    end
  end

  wire scl_h = scl_sq[1];
  wire scl_p = scl_sq[2];
  wire sda_h = sda_sq[1];
  wire sda_p = sda_sq[2];
  wire scl_rise = scl_h & ~scl_p;
  wire scl_fall = ~scl_h & scl_p;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  ibf_state_e state_q, state_d, next_w;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d, tx_q, tx_d;
  logic [5:0] hold_q, hold_d, since_fall_q;
  logic active_q, seen_low_q, full_q, ack_drv_q;
  logic pend_q, stretch_q, armed_q;
  logic pend_d, stretch_d, armed_d, full_d, ack_drv_d;
  logic sda_oe_d;

  function automatic logic hi_match(input logic [7:0] b,
                                    input logic [9:0] own);
    hi_match = b[7:1] == {HI_ADDR_TAG, own[9:8]};
  endfunction

  // ----------------------------------------------------------------
  // Conditions
  // ----------------------------------------------------------------
  // A data edge while the clock stays high is never a data bit
  wire cond_w = scl_h & scl_p & (sda_h ^ sda_p);
  wire start_w = cond_w & ~sda_h;
  // A Start/Stop glitch with no clock low yields a Start only
  wire stop_w = cond_w & sda_h & seen_low_q;
  wire restart_w = start_w & active_q;
  wire clr_w = start_w | stop_w;

  // ----------------------------------------------------------------
  // Byte framing and address decode
  // ----------------------------------------------------------------
  wire byte_end = scl_fall & (cnt_q == BITS_DATA);
  wire unit_end = scl_fall & (cnt_q == BITS_UNIT);
  wire rw_w = sh_q[0];
  wire m7_w = ~cfg_in.addr_10bit &
              (sh_q[7:1] == cfg_in.own_address_value[7:1]);
  wire mhi_w = cfg_in.addr_10bit &
               hi_match(sh_q, cfg_in.own_address_value);
  wire lo_w = sh_q == cfg_in.own_address_value[7:0];
  // A 10-bit read is only honoured once both address bytes matched
  wire ack_addr = m7_w | (mhi_w & (~rw_w | full_q));
  wire rcv_st = (state_q == ST_ADDR) | (state_q == ST_ADDR_LO) |
                (state_q == ST_RX);
  wire ack_w = (state_q == ST_ADDR) ? ack_addr :
               (state_q == ST_ADDR_LO) ? lo_w :
               (state_q == ST_RX);
  wire tx_now = (state_q == ST_TX) & ~ack_drv_q;
  wire tx_go = (state_q == ST_TX) & tx_valid_in;

  assign next_w = (state_q == ST_ADDR) ?
                    (m7_w ? (rw_w ? ST_TX : ST_RX) :
                     mhi_w ? (rw_w ? (full_q ? ST_TX : ST_SKIP)
                                   : ST_ADDR_LO) : ST_SKIP) :
                  (state_q == ST_ADDR_LO) ?
                    (lo_w ? ST_RX : ST_SKIP) : state_q;

  // Master answers our byte with a high level: the read is over
  wire nack_w = scl_rise & (cnt_q == BITS_DATA) & tx_now & sda_h;
  // Losing the line while sending a one ends our part at once
  wire coll_w = scl_rise & tx_now & (cnt_q < BITS_DATA) &
                ~sda_oe_out & ~sda_h;

  assign state_d = start_w ? ST_ADDR :
                   stop_w ? ST_IDLE :
                   (coll_w | nack_w) ? ST_SKIP :
                   byte_end ? next_w : state_q;

  // Edges are only counted, so a held-low clock simply waits
  assign cnt_d = (clr_w | unit_end) ? CNT_RST :
                 (scl_rise & (state_q != ST_IDLE) & (cnt_q < BITS_UNIT))
                   ? cnt_q + 4'h1 : cnt_q;
  assign sh_d = (scl_rise & (cnt_q < BITS_DATA))
                  ? {sh_q[6:0], sda_h} : sh_q;

  // ----------------------------------------------------------------
  // Data drive with hold timing
  // ----------------------------------------------------------------
  wire [5:0] hold_cyc = cfg_in.data_hold_extend ?
                        6'(HOLD_EXT_CYC) : 6'(HOLD_DEF_CYC);
  wire fall_ld = scl_fall & (state_q != ST_IDLE);
  wire apply_w = hold_q == 6'h01;
  wire stretch_ld = stretch_q & ~armed_q & tx_valid_in &
                    (hold_q == HOLD_RST);
  wire load_w = (unit_end & tx_go) | stretch_ld;
  // Clock goes free one cycle after the first bit is out, never with it
  wire drop_w = armed_q & (hold_q == HOLD_RST);
  wire fall_pend = (cnt_q == BITS_DATA) ? (rcv_st & ack_w) :
                   (cnt_q == BITS_UNIT) ? (tx_go & ~tx_data_in[7]) :
                   (tx_now & (cnt_q != CNT_RST) &
                    ~tx_q[~cnt_q[2:0]]);

  assign pend_d = (clr_w | coll_w) ? 1'b0 :
                  fall_ld ? fall_pend :
                  stretch_ld ? ~tx_data_in[7] : pend_q;
  // Drive changes only after the hold count from the clock fall
  assign hold_d = clr_w ? HOLD_RST :
                  (fall_ld | stretch_ld) ? hold_cyc :
                  (hold_q != HOLD_RST) ? hold_q - 6'h01 : HOLD_RST;
  assign sda_oe_d = (clr_w | coll_w | nack_w) ? 1'b0 :
                    apply_w ? pend_q : sda_oe_out;
  assign ack_drv_d = byte_end ? (rcv_st & ack_w) :
                     (clr_w | unit_end) ? 1'b0 : ack_drv_q;
  assign tx_d = load_w ? tx_data_in : tx_q;

  // Hold the clock until the next byte to send is at hand
  assign stretch_d = (clr_w | coll_w) ? 1'b0 :
                     (unit_end & (state_q == ST_TX) & ~tx_valid_in)
                       ? 1'b1 :
                     drop_w ? 1'b0 : stretch_q;
  assign armed_d = clr_w ? 1'b0 : stretch_ld ? 1'b1 :
                   drop_w ? 1'b0 : armed_q;
  assign full_d = stop_w ? 1'b0 :
                  (byte_end & (state_q == ST_ADDR) & mhi_w & ~rw_w)
                    ? 1'b0 :
                  (byte_end & (state_q == ST_ADDR_LO) & lo_w)
                    ? 1'b1 : full_q;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      state_q <= ST_IDLE;
      cnt_q <= CNT_RST;
      sh_q <= BYTE_RST;
      tx_q <= BYTE_RST;
      hold_q <= HOLD_RST;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      tx_q <= tx_d;
      hold_q <= hold_d;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      pend_q <= 1'b0;
      stretch_q <= 1'b0;
      armed_q <= 1'b0;
      full_q <= 1'b0;
      ack_drv_q <= 1'b0;
    end
    else
    begin
      pend_q <= pend_d;
      stretch_q <= stretch_d;
      armed_q <= armed_d;
      full_q <= full_d;
      ack_drv_q <= ack_drv_d;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      active_q <= 1'b0;
      seen_low_q <= 1'b0;
    end
    else
    begin
      active_q <= start_w | (active_q & ~stop_w);
      seen_low_q <= ~start_w & (seen_low_q | ~scl_h);
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      scl_out <= 1'b0;
      sda_out <= 1'b0;
      scl_oe_out <= 1'b0;
      sda_oe_out <= 1'b0;
      rx_data_out <= BYTE_RST;
      evt_out <= EVT_RST;
      bus_active_out <= 1'b0;
      bus_idle_out <= 1'b0;
      read_mode_out <= 1'b0;
    end
    else
    begin
      scl_out <= 1'b0;
      sda_out <= 1'b0;
      scl_oe_out <= stretch_d;
      sda_oe_out <= sda_oe_d;
      if (byte_end & (state_q == ST_RX))
        rx_data_out <= sh_q;
      evt_out.start <= start_w & ~active_q;
      evt_out.restart <= restart_w;
      evt_out.stop <= stop_w;
      evt_out.collision <= coll_w;
      evt_out.rx_valid <= byte_end & (state_q == ST_RX);
      evt_out.tx_taken <= load_w;
      bus_active_out <= active_q;
      bus_idle_out <= ~active_q & scl_h & sda_h;
      read_mode_out <= state_q == ST_TX;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      since_fall_q <= FALL_MAX;
    else if (scl_fall)
      since_fall_q <= HOLD_RST;
    else if (since_fall_q != FALL_MAX)
      since_fall_q <= since_fall_q + 6'h01;
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  a_start_event: assert property (
    start_w |=> (evt_out.start | evt_out.restart) && bus_active_out
                == $past(active_q) ##1 bus_active_out)
    else $error("start not reported");

  a_stop_after_low: assert property (
    evt_out.stop |-> $past(seen_low_q, 2) && !$past(start_w, 2))
    else $error("stop accepted without clock low");

  a_cond_no_bit: assert property (
    cond_w |=> $stable(sh_q))
    else $error("bus condition shifted as data");

  a_hold_extend: assert property (
    (cfg_in.data_hold_extend && $changed(sda_oe_out) &&
     !$past(clr_w || coll_w || nack_w) && !$past(stretch_ld, 1))
      |-> since_fall_q >= HOLD_EXT_CYC)
    else $error("data hold too short");

  a_collision_flag: assert property (
    coll_w |=> evt_out.collision && state_q == ST_SKIP ##1 !sda_oe_out)
    else $error("collision not flagged");

  a_restart_reset: assert property (
    restart_w |=> state_q == ST_ADDR && cnt_q == CNT_RST &&
                  !sda_oe_out && evt_out.restart)
    else $error("restart did not reset slave");

  a_addr_ack: assert property (
    (byte_end && state_q == ST_ADDR) |=> pend_q == $past(ack_addr))
    else $error("address ack mismatch");

  a_ninth_release: assert property (
    (byte_end && state_q == ST_TX) |=> !pend_q)
    else $error("sender kept data during ack");

endmodule

// file: verification/ibf_bus_master.sv
/*
  Behavioural bus master facing the framing block.
  Assumes the bench resolves both lines from all enables with pull-ups.
*/
module ibf_bus_master (
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_oe_out,
  output logic sda_oe_out
);
  timeunit 1ns;
  timeprecision 1ns;
  int t_lo = 60;
  int t_hi = 20;
  int n_to = 0;
  initial
  begin
    scl_oe_out = 1'b0;
    sda_oe_out = 1'b0;
  end
  // Bounded so a slave that never lets go cannot hang the run
  task automatic rise();
    int n;
    n = 0;
    scl_oe_out = 1'b0;
    while (scl_in !== 1'b1 && n < 20000)
    begin
      #10;
      n++;
    end
    if (n >= 20000)
      n_to++;
  endtask
  task automatic put_bit(input logic b, output logic r);
    #(t_lo / 2);
    sda_oe_out = ~b;
    #(t_lo / 2);
    rise();
    #(t_hi / 2);
    r = sda_in;
    #(t_hi / 2);
    scl_oe_out = 1'b1;
  endtask
  task automatic xfer(input logic [7:0] b, input logic a,
                      output logic [7:0] r, output logic ack);
    for (int i = 7; i >= 0; i--)
      put_bit(b[i], r[i]);
    put_bit(a, ack);
  endtask
  // Full low phase first, so a late slave release is not read as Stop
  task automatic start();
    if (scl_oe_out)
    begin
      sda_oe_out = 1'b0;
      #(t_lo);
      rise();
    end
    #40;
    sda_oe_out = 1'b1;
    #40;
    scl_oe_out = 1'b1;
  endtask
  task automatic stop();
    #(t_lo / 2);
    sda_oe_out = 1'b1;
    #(t_lo / 2);
    rise();
    #40;
    sda_oe_out = 1'b0;
    #40;
  endtask
  task automatic glitch();
    sda_oe_out = 1'b1;
    #40;
    sda_oe_out = 1'b0;
    #40;
  endtask
endmodule

// file: verification/tb_top.sv
/*
  Self-checking bench for the bus framing block, slave side.
  Assumes ibf_pkg and the behavioural master model are compiled first.
*/
module tb_top
  import ibf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  ibf_cfg_s cfg_in = '0;
  logic [7:0] tx_data_in = 8'h00;
  logic tx_valid_in = 1'b0;
  logic scl_o, scl_oe, sda_o, sda_oe, m_scl, m_sda, scl_w, sda_w;
  logic [7:0] rx_data, d, e;
  logic c, active, idle, rmode;
  ibf_evt_s evt;
  logic [6:0] a7;
  logic [9:0] a10;
  logic [7:0] txq [$];
  int cnt [6] = '{0, 0, 0, 0, 0, 0};
  int errors = 0;
  int n_checks = 0;
  int seed = 32'hDB880C61;
  bit chk_dc = 1'b1;
  realtime t_fall = 0.0;

  always #5 clk_in = ~clk_in;
  assign scl_w = (scl_oe ? scl_o : 1'b1) & ~m_scl;
  assign sda_w = (sda_oe ? sda_o : 1'b1) & ~m_sda;

  ibf_framing u_dut (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .scl_in(scl_w),
    .sda_in(sda_w), .cfg_in(cfg_in), .tx_data_in(tx_data_in),
    .tx_valid_in(tx_valid_in), .scl_out(scl_o), .scl_oe_out(scl_oe),
    .sda_out(sda_o), .sda_oe_out(sda_oe), .rx_data_out(rx_data),
    .evt_out(evt), .bus_active_out(active), .bus_idle_out(idle),
    .read_mode_out(rmode)
  );
  ibf_bus_master u_mst (
    .scl_in(scl_w), .sda_in(sda_w), .scl_oe_out(m_scl),
    .sda_oe_out(m_sda)
  );

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    errors += u_mst.n_to;
    $display("checks=%0d errors=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] b, input logic exp_ack);
    logic [7:0] r;
    logic a;
    u_mst.xfer(b, 1'b1, r, a);
    chk(a, exp_ack);
  endtask
  task automatic rd(input logic last);
    logic [7:0] r;
    logic a;
    u_mst.xfer(8'hFF, last, r, a);
    chk(r, txq.pop_front());
  endtask

  // ----------------------------------------------------------------
  // Monitors
  // ----------------------------------------------------------------
  always @(posedge clk_in)
  begin
    for (int i = 0; i < 6; i++)
      if (evt[i] === 1'b1)
        cnt[i]++;
    if (evt.tx_taken === 1'b1)
    begin
      txq.push_back(tx_data_in);
      tx_data_in <= 8'($random(seed));
    end
  end
  always @(negedge scl_w) t_fall = $realtime;
  always @(sda_oe)
    if (rst_b_in === 1'b1 && chk_dc)
    begin
      chk({scl_w, sda_o}, 2'h0);
      if (cfg_in.data_hold_extend === 1'b1)
        chk($realtime - t_fall >= 300.0, 1'b1);
    end
  initial
  begin
    repeat (90000) @(posedge clk_in);
    errors++;
    end_sim();
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial
  begin
    repeat (8) @(posedge clk_in);
    rst_b_in <= 1'b1;
    // Top bit clear keeps clear of the 10-bit address prefix
    a7 = 7'($random(seed)) & 7'h3F;
    a10 = 10'($random(seed));
    tx_data_in <= 8'($random(seed));
    cfg_in.own_address_value <= {2'h0, a7, 1'b0};
    repeat (4) @(posedge clk_in);
    chk({idle, active, rmode, sda_oe, scl_oe}, 5'h10);
    // Bus edges land on falling clock edges, so rising-edge sampling never races them
    @(negedge clk_in);
    u_mst.start();
    chk({active, 4'(cnt[5])}, 5'h11);
    wr({a7, 1'b0}, 1'b0);
    repeat (3)
    begin
      d = 8'($random(seed));
      wr(d, 1'b0);
      chk(rx_data, d);
    end
    u_mst.start();
    chk(cnt[4], 1);
    wr({a7 ^ 7'h01, 1'b0}, 1'b1);
    wr(8'h5A, 1'b1);
    chk(cnt[1], 3);
    u_mst.stop();
    repeat (5) @(posedge clk_in);
    chk({active, idle, 4'(cnt[3])}, 6'h11);
    @(negedge clk_in);
    u_mst.start();
    wr({a7, 1'b1}, 1'b0);
    chk(rmode, 1'b1);
    fork
      rd(1'b0);
      begin
        repeat (100) @(posedge clk_in);
        chk({scl_oe, scl_o}, 2'h2);
        tx_valid_in <= 1'b1;
      end
    join
    rd(1'b0);
    rd(1'b1);
    u_mst.stop();
    chk({rmode, 4'(cnt[0])}, 5'h03);
    u_mst.start();
    wr({a7, 1'b1}, 1'b0);
    repeat (10) @(posedge clk_in);
    @(negedge clk_in);
    e = txq.pop_front();
    chk_dc = 1'b0;
    u_mst.xfer(~e, 1'b1, d, c);
    chk(cnt[2], e != 8'h00);
    u_mst.stop();
    chk_dc = 1'b1;
    u_mst.glitch();
    chk({4'(cnt[5]), 4'(cnt[3])}, 8'h43);
    u_mst.start();
    u_mst.stop();
    chk(cnt[3], 4);
    @(posedge clk_in);
    cfg_in.data_hold_extend <= 1'b1;
    u_mst.t_lo = 800;
    @(negedge clk_in);
    u_mst.start();
    wr({a7, 1'b0}, 1'b0);
    d = 8'($random(seed));
    wr(d, 1'b0);
    chk(rx_data, d);
    u_mst.start();
    wr({a7, 1'b1}, 1'b0);
    rd(1'b1);
    u_mst.stop();
    @(posedge clk_in);
    cfg_in <= '{a10, 1'b1, 1'b0};
    u_mst.t_lo = 60;
    @(negedge clk_in);
    u_mst.start();
    wr({5'h1E, a10[9:8], 1'b1}, 1'b1);
    u_mst.stop();
    u_mst.start();
    wr({5'h1E, a10[9:8], 1'b0}, 1'b0);
    wr(a10[7:0], 1'b0);
    u_mst.start();
    wr({5'h1E, a10[9:8], 1'b1}, 1'b0);
    rd(1'b1);
    u_mst.stop();
    // The Start after the glitch finds the bus still active: a Restart
    chk(cnt[5], 7);
    chk(cnt[4], 4);
    chk(cnt[3], 7);
    chk(cnt[1], 4);
    chk(cnt[0], 6);
    end_sim();
  end
endmodule
